// ===== mdu_map.svh
// Purpose: Constants of the multiply and divide instruction unit
// Assumes: Included by the unit and its divider, bare name
// Notes:   Definitions only
`ifndef MDU_MAP_SVH
`define MDU_MAP_SVH
// What this block does
// - Operands from general, parameter or immediate
// - Suffix selects six operand-area combinations
// - Twelve multiply and six divide variants
// - Multiply first by second into destination
// - Half multiply: low at dst, high dst+1
// - Products always go to general area
// - Full multiply: register pairs, four result words
// - Full multiply: high pair dst+3/dst+2
// - Divide first by second into destination
// - Quotient lower address, remainder higher address
// - Half divide: quotient dst, remainder dst+1
// - Quotients always go to general area

`define MDU_WORD_W      16
`define MDU_DIV_STEPS   5'h10
`define MDU_DIV0_QUO    16'hFFFF
`define MDU_LAST_HALF   2'h1
`define MDU_LAST_FULL   2'h3
`define MDU_AREA_GEN    1'b0
`define MDU_AREA_PAR    1'b1
`define MDU_NO_WORD     3'h4
`endif

// ===== mdu_pkg.sv
// Purpose: Types of the multiply and divide instruction unit
// Assumes: Nothing
// Notes:   Constants live in mdu_map.svh
package mdu_pkg;

   typedef enum logic [1:0] {
      multiply_half_width = 2'h0,
      multiply_full_width = 2'h1,
      divide_half_width   = 2'h2
   } mdu_kind_e;

   typedef enum logic [2:0] {
      src_general_general     = 3'h0,
      src_immediate_general   = 3'h1,
      src_parameter_general   = 3'h2,
      src_immediate_parameter = 3'h3,
      src_general_parameter   = 3'h4,
      src_parameter_parameter = 3'h5
   } mdu_src_e;

   typedef enum logic [2:0] {
      st_idle  = 3'b000,
      st_read  = 3'b001,
      st_latch = 3'b010,
      st_exec  = 3'b011,
      st_div   = 3'b100,
      st_write = 3'b101
   } mdu_state_e;

endpackage

// ===== mdu_div_if.sv
// Purpose: Link between the instruction unit and its divider
// Assumes: One clock domain
// Notes:   start is a one-cycle pulse, done likewise
`timescale 1ns/1ps
interface mdu_div_if;
   logic        start;
   logic [15:0] dividend;
   logic [15:0] divisor;
   logic [15:0] quotient;
   logic [15:0] remainder;
   logic        done;
   modport unit (output start, dividend, divisor, input quotient, remainder, done);
   modport div  (input start, dividend, divisor, output quotient, remainder, done);
endinterface

// ===== mdu_divider.sv
// Purpose: Serial restoring divider, one quotient bit per cycle
// Assumes: start only while idle; clk_en freezes all state
// Notes:   Zero divisor answers in one cycle with a fixed quotient and the dividend as remainder
`timescale 1ns/1ps
`include "mdu_map.svh"
module mdu_divider (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic clk_en,
   mdu_div_if.div    d
);
   logic        busy;
   logic        next_busy;
   logic [4:0]  step;
   logic [4:0]  next_step;
   logic [15:0] q;
   logic [15:0] next_q;
   logic [15:0] r;
   logic [15:0] next_r;
   logic [15:0] dsr;
   logic [15:0] next_dsr;
   logic [15:0] dvd;
   logic [15:0] next_dvd;
   logic        done;
   logic        next_done;
   logic [16:0] shifted;
   logic [16:0] diff;

   always_comb begin
      next_busy = busy;
      next_step = step;
      next_q    = q;
      next_r    = r;
      next_dsr  = dsr;
      next_dvd  = dvd;
      next_done = 1'b0;
      shifted   = {r, q[15]};
      diff      = shifted - {1'b0, dsr};
      if (d.start && !busy) begin
         next_dvd = d.dividend;
         next_dsr = d.divisor;
         if (d.divisor == 16'h0000) begin
            // No iterations: a zero divisor must not hang the program
            next_q    = `MDU_DIV0_QUO;
            next_r    = d.dividend;
            next_done = 1'b1;
         end else begin
            next_q    = d.dividend;
            next_r    = 16'h0000;
            next_step = `MDU_DIV_STEPS;
            next_busy = 1'b1;
         end
      end else if (busy) begin
         if (!diff[16]) begin
            next_r = diff[15:0];
            next_q = {q[14:0], 1'b1};
         end else begin
            next_r = shifted[15:0];
            next_q = {q[14:0], 1'b0};
         end
         next_step = step - 5'h01;
         if (step == 5'h01) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         step <= 5'h00;
         q    <= 16'h0000;
         r    <= 16'h0000;
         dsr  <= 16'h0000;
         dvd  <= 16'h0000;
         done <= 1'b0;
      end else if (clk_en) begin
         busy <= next_busy;
         step <= next_step;
         q    <= next_q;
         r    <= next_r;
         dsr  <= next_dsr;
         dvd  <= next_dvd;
         done <= next_done;
      end
   end

   assign d.quotient  = q;
   assign d.remainder = r;
   assign d.done      = done;

   div_result_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      done |-> ((dsr == 16'h0000) ? (q == `MDU_DIV0_QUO && r == dvd)
              : ({16'h0000, q} * {16'h0000, dsr} + {16'h0000, r} == {16'h0000, dvd}
                 && r < dsr)))
      else $error("divider result inconsistent with operands");

   div_steps_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      busy |-> (step != 5'h00 && step <= `MDU_DIV_STEPS))
      else $error("divider step count out of range");
endmodule

// ===== mdu_unit.sv
// Purpose: Multiply and divide instructions of the register program
// Assumes: Register areas answer a read one cycle after rd_en
// Notes:   Unsigned arithmetic; results written one word per cycle
`timescale 1ns/1ps
`include "mdu_map.svh"
module mdu_unit #(
   parameter int AW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          rstn,
   input  wire logic          clk_en,
   input  wire logic          op_valid,
   input  wire logic [1:0]    op_kind,
   input  wire logic [2:0]    op_src,
   input  wire logic [31:0]   op_a,
   input  wire logic [AW-1:0] op_b,
   input  wire logic [AW-1:0] op_dst,
   output logic               busy,
   output logic               done,
   output logic               err,
   output logic               rd_en,
   output logic               rd_area,
   output logic [AW-1:0]      rd_addr,
   input  wire logic [15:0]   rd_data,
   output logic               wr_en,
   output logic [AW-1:0]      wr_addr,
   output logic [15:0]        wr_data
);
   mdu_pkg::mdu_state_e state;
   mdu_pkg::mdu_state_e next_state;
   mdu_pkg::mdu_kind_e  kind_q;
   mdu_pkg::mdu_kind_e  next_kind_q;
   mdu_pkg::mdu_src_e   src_q;
   mdu_pkg::mdu_src_e   next_src_q;
   logic [AW-1:0]       a_q;
   logic [AW-1:0]       next_a_q;
   logic [AW-1:0]       b_q;
   logic [AW-1:0]       next_b_q;
   logic [AW-1:0]       dst_q;
   logic [AW-1:0]       next_dst_q;
   logic [31:0]         opa;
   logic [31:0]         next_opa;
   logic [31:0]         opb;
   logic [31:0]         next_opb;
   logic [63:0]         res;
   logic [63:0]         next_res;
   logic [1:0]          idx;
   logic [1:0]          next_idx;
   logic [1:0]          out_idx;
   logic [1:0]          next_out_idx;
   logic                div_start;
   logic                next_div_start;
   logic                next_busy;
   logic                next_done;
   logic                next_err;
   logic                next_rd_en;
   logic                next_rd_area;
   logic [AW-1:0]       next_rd_addr;
   logic                next_wr_en;
   logic [AW-1:0]       next_wr_addr;
   logic [15:0]         next_wr_data;
   logic                legal;
   logic                a_imm;
   logic                a_par;
   logic                b_par;
   logic [2:0]          nw;
   logic [1:0]          last_idx;

   mdu_div_if dl ();

   mdu_divider mdu_divider_i (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .d        (dl.div)
   );

   assign dl.start    = div_start;
   assign dl.dividend = opa[15:0];
   assign dl.divisor  = opb[15:0];

   // Operand areas by suffix
   function automatic logic imm_a(input mdu_pkg::mdu_src_e s);
      return s == mdu_pkg::src_immediate_general || s == mdu_pkg::src_immediate_parameter;
   endfunction

   function automatic logic par_a(input mdu_pkg::mdu_src_e s);
      return s == mdu_pkg::src_parameter_general || s == mdu_pkg::src_parameter_parameter;
   endfunction

   function automatic logic par_b(input mdu_pkg::mdu_src_e s);
      return s == mdu_pkg::src_immediate_parameter || s == mdu_pkg::src_general_parameter
          || s == mdu_pkg::src_parameter_parameter;
   endfunction

   // Next operand word to fetch at or after position from; words are A lo, A hi, B lo, B hi.
   // Full-width operands come from register pairs, the higher address holding the high half.
   function automatic logic [2:0] next_word(input logic [2:0] from,
                                            input mdu_pkg::mdu_kind_e k,
                                            input mdu_pkg::mdu_src_e s);
      logic [2:0] found;
      logic       need;
      found = `MDU_NO_WORD;
      for (int i = 3; i >= 0; i--) begin
         need = (i >= 2 || !imm_a(s)) && (i[0] == 1'b0 || k == mdu_pkg::multiply_full_width);
         if (need && 3'(i) >= from) begin
            found = 3'(i);
         end
      end
      return found;
   endfunction

   assign a_imm    = imm_a(src_q);
   assign a_par    = par_a(src_q);
   assign b_par    = par_b(src_q);
   assign last_idx = (kind_q == mdu_pkg::multiply_full_width) ? `MDU_LAST_FULL : `MDU_LAST_HALF;
   // Both multiply widths, the half-width divide and all six suffixes are accepted
   assign legal    = (op_kind <= 2'h2) && (op_src <= 3'h5);
   assign nw       = next_word({1'b0, idx} + 3'h1, kind_q, src_q);

   always_comb begin
      next_state     = state;
      next_kind_q    = kind_q;
      next_src_q     = src_q;
      next_a_q       = a_q;
      next_b_q       = b_q;
      next_dst_q     = dst_q;
      next_opa       = opa;
      next_opb       = opb;
      next_res       = res;
      next_idx       = idx;
      next_out_idx   = out_idx;
      next_div_start = 1'b0;
      next_done      = 1'b0;
      next_err       = 1'b0;
      next_rd_en     = 1'b0;
      next_rd_area   = rd_area;
      next_rd_addr   = rd_addr;
      next_wr_en     = 1'b0;
      next_wr_addr   = wr_addr;
      next_wr_data   = wr_data;
      unique case (state)
         mdu_pkg::st_idle: begin
            if (op_valid && !legal) begin
               next_err = 1'b1;
            end else if (op_valid) begin
               next_kind_q = mdu_pkg::mdu_kind_e'(op_kind);
               next_src_q  = mdu_pkg::mdu_src_e'(op_src);
               next_a_q    = op_a[AW-1:0];
               next_b_q    = op_b;
               next_dst_q  = op_dst;
               next_opb    = 32'h0000_0000;
               // Immediate operand carried in the instruction
               if (!imm_a(mdu_pkg::mdu_src_e'(op_src))) begin
                  next_opa = 32'h0000_0000;
               end else if (op_kind == 2'h1) begin
                  next_opa = op_a;
               end else begin
                  next_opa = {16'h0000, op_a[15:0]};
               end
               next_idx   = 2'(next_word(3'h0, mdu_pkg::mdu_kind_e'(op_kind),
                                         mdu_pkg::mdu_src_e'(op_src)));
               next_state = mdu_pkg::st_read;
            end
         end
         mdu_pkg::st_read: begin
            next_rd_en   = 1'b1;
            next_rd_area = idx[1] ? b_par : a_par;
            next_rd_addr = (idx[1] ? b_q : a_q) + AW'(idx[0]);
            next_state   = mdu_pkg::st_latch;
         end
         mdu_pkg::st_latch: begin
            // Area answers the cycle after rd_en, so the request cycle is waited out
            if (!rd_en) begin
               if (idx[1]) begin
                  next_opb[16*idx[0] +: 16] = rd_data;
               end else begin
                  next_opa[16*idx[0] +: 16] = rd_data;
               end
               if (nw == `MDU_NO_WORD) begin
                  next_state = mdu_pkg::st_exec;
               end else begin
                  next_idx   = nw[1:0];
                  next_state = mdu_pkg::st_read;
               end
            end
         end
         mdu_pkg::st_exec: begin
            next_out_idx = 2'h0;
            if (kind_q == mdu_pkg::divide_half_width) begin
               next_div_start = 1'b1;
               next_state     = mdu_pkg::st_div;
            end else begin
               // Half-width operands are zero-extended, so one product serves both widths
               next_res   = {32'h0000_0000, opa} * {32'h0000_0000, opb};
               next_state = mdu_pkg::st_write;
            end
         end
         mdu_pkg::st_div: begin
            if (dl.done) begin
               // Quotient in the low word, remainder above it
               next_res   = {32'h0000_0000, dl.remainder, dl.quotient};
               next_state = mdu_pkg::st_write;
            end
         end
         mdu_pkg::st_write: begin
            // Write port only reaches the general area
            next_wr_en   = 1'b1;
            next_wr_addr = dst_q + AW'(out_idx);
            next_wr_data = res[16*out_idx +: 16];
            if (out_idx == last_idx) begin
               next_done  = 1'b1;
               next_state = mdu_pkg::st_idle;
            end else begin
               next_out_idx = out_idx + 2'h1;
            end
         end
         default: begin
            next_state = mdu_pkg::st_idle;
         end
      endcase
      next_busy = (next_state != mdu_pkg::st_idle);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state     <= mdu_pkg::st_idle;
         kind_q    <= mdu_pkg::multiply_half_width;
         src_q     <= mdu_pkg::src_general_general;
         a_q       <= '0;
         b_q       <= '0;
         dst_q     <= '0;
         opa       <= 32'h0000_0000;
         opb       <= 32'h0000_0000;
         res       <= 64'h0000_0000_0000_0000;
         idx       <= 2'h0;
         out_idx   <= 2'h0;
         div_start <= 1'b0;
         busy      <= 1'b0;
         done      <= 1'b0;
         err       <= 1'b0;
         rd_en     <= 1'b0;
         rd_area   <= `MDU_AREA_GEN;
         rd_addr   <= '0;
         wr_en     <= 1'b0;
         wr_addr   <= '0;
         wr_data   <= 16'h0000;
      end else if (clk_en) begin
         state     <= next_state;
         kind_q    <= next_kind_q;
         src_q     <= next_src_q;
         a_q       <= next_a_q;
         b_q       <= next_b_q;
         dst_q     <= next_dst_q;
         opa       <= next_opa;
         opb       <= next_opb;
         res       <= next_res;
         idx       <= next_idx;
         out_idx   <= next_out_idx;
         div_start <= next_div_start;
         busy      <= next_busy;
         done      <= next_done;
         err       <= next_err;
         rd_en     <= next_rd_en;
         rd_area   <= next_rd_area;
         rd_addr   <= next_rd_addr;
         wr_en     <= next_wr_en;
         wr_addr   <= next_wr_addr;
         wr_data   <= next_wr_data;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   accept_busy_a: assert property (
      (clk_en && op_valid && !busy && legal) |=> busy)
      else $error("legal instruction not accepted");

   imm_noread_a: assert property (
      (state == mdu_pkg::st_latch && rd_en) |-> !(!idx[1] && a_imm))
      else $error("immediate operand fetched from an area");

   area_sel_a: assert property (
      (state == mdu_pkg::st_latch && rd_en) |-> rd_area == (idx[1] ? b_par : a_par))
      else $error("operand read from wrong area");

   mul_result_a: assert property (
      (state == mdu_pkg::st_write && kind_q != mdu_pkg::divide_half_width)
      |-> res == {32'h0000_0000, opa} * {32'h0000_0000, opb})
      else $error("product does not match operands");

   mul_half_a: assert property (
      (wr_en && kind_q == mdu_pkg::multiply_half_width && out_idx == 2'h1 && done)
      |-> (wr_data == res[31:16] && wr_addr == dst_q + AW'(1)))
      else $error("half product high word misplaced");

   mul_full_a: assert property (
      (wr_en && kind_q == mdu_pkg::multiply_full_width && done)
      |-> (wr_data == res[63:48] && wr_addr == dst_q + AW'(3)))
      else $error("full product high word misplaced");

   write_count_a: assert property (
      done |-> (wr_en && out_idx == last_idx && $past(wr_en) && !busy))
      else $error("result word count wrong");

   div_place_a: assert property (
      (state == mdu_pkg::st_write && kind_q == mdu_pkg::divide_half_width && opb[15:0] != 0)
      |-> (res[15:0] == opa[15:0] / opb[15:0] && res[31:16] == opa[15:0] % opb[15:0]))
      else $error("quotient or remainder misplaced");

   freeze_a: assert property (
      !clk_en |=> ($stable(state) && $stable(wr_en)))
      else $error("state moved while clock enable low");
endmodule

// ===== mdu_unit_tb_top.sv
// Purpose: Self-checking bench for the multiply and divide instruction unit
// Assumes: Register areas answer one cycle after rd_en; unsigned arithmetic
// Notes:   Bench models both register areas; writes land in the general one
`timescale 1ns/1ps
module mdu_unit_tb_top;
   logic        core_clk;
   logic        rstn;
   logic        clk_en;
   logic        op_valid;
   logic [1:0]  op_kind;
   logic [2:0]  op_src;
   logic [31:0] op_a;
   logic [15:0] op_b;
   logic [15:0] op_dst;
   logic        busy;
   logic        done;
   logic        err;
   logic        rd_en;
   logic        rd_area;
   logic [15:0] rd_addr;
   logic [15:0] rd_data;
   logic        wr_en;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic [15:0] gen   [0:255];
   logic [15:0] par   [0:255];
   logic [1:0]  a_ar  [0:5] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h1};
   logic [1:0]  b_ar  [0:5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1};
   int          err_count;
   int          checks;
   int          wr_cnt;

   mdu_unit #(.AW(16)) mdu_unit_i (
      .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .op_valid(op_valid),
      .op_kind(op_kind), .op_src(op_src), .op_a(op_a), .op_b(op_b), .op_dst(op_dst),
      .busy(busy), .done(done), .err(err), .rd_en(rd_en), .rd_area(rd_area),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data)
   );

   always #12.5 core_clk = ~core_clk;

   // Read data is valid only the cycle after rd_en; otherwise it keeps toggling
   always @(posedge core_clk) begin
      if (clk_en === 1'b1 && rd_en === 1'b1) begin
         rd_data <= rd_area ? par[rd_addr[7:0]] : gen[rd_addr[7:0]];
      end else if (clk_en === 1'b1) begin
         rd_data <= ~rd_data;
      end
      if (clk_en === 1'b1 && wr_en === 1'b1) begin
         gen[wr_addr[7:0]] <= wr_data;
         wr_cnt <= wr_cnt + 1;
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic give_verdict;
      if (err_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Area 0 general, 1 parameter, 2 immediate
   function automatic logic [31:0] fetch(input logic [1:0] ar, input logic [31:0] v,
                                         input bit full);
      logic [7:0] x;
      x = v[7:0];
      case (ar)
         2'h0:    fetch = full ? {gen[x + 8'h01], gen[x]} : {16'h0000, gen[x]};
         2'h1:    fetch = full ? {par[x + 8'h01], par[x]} : {16'h0000, par[x]};
         default: fetch = full ? v : {16'h0000, v[15:0]};
      endcase
   endfunction

   task automatic issue(input logic [1:0] k, input logic [2:0] s, input logic [31:0] a,
                        input logic [15:0] b, input logic [15:0] dst);
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_kind  <= k;
      op_src   <= s;
      op_a     <= a;
      op_b     <= b;
      op_dst   <= dst;
      @(posedge core_clk);
      op_valid <= 1'b0;
      // Scrambled operands after acceptance catch a unit that fails to latch
      op_a     <= ~a;
      op_b     <= ~b;
      op_dst   <= ~dst;
      #1;
   endtask

   task automatic run_op(input logic [1:0] k, input logic [2:0] s, input logic [31:0] a,
                         input logic [15:0] b, input logic [15:0] dst, input int stall);
      int n;
      wr_cnt = 0;
      issue(k, s, a, b, dst);
      chk(busy, 1, "busy after accept");
      if (stall > 0) begin
         @(posedge core_clk);
         clk_en <= 1'b0;
         repeat (stall) @(posedge core_clk);
         clk_en <= 1'b1;
         #1;
      end
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(done, 1, "done not seen");
      @(posedge core_clk);
      #1;
      chk({done, busy}, 0, "done not single or still busy");
   endtask

   task automatic t_mul(input bit full);
      logic [63:0] av, bv, prod;
      logic [31:0] a;
      logic [15:0] dst;
      int          nw;
      nw = full ? 4 : 2;
      for (int s = 0; s < 6; s++) begin
         gen[8'h10] = 16'hFFFF - 16'(s);
         gen[8'h11] = 16'hFFFE;
         par[8'h10] = 16'hFFFD - 16'(s);
         par[8'h11] = 16'hFFFF;
         gen[8'h20] = 16'hFFFF;
         gen[8'h21] = 16'h8001 + 16'(s);
         par[8'h20] = 16'hFFFB;
         par[8'h21] = 16'h7FFF - 16'(s);
         // Upper immediate half must be ignored by the half-width form
         a = (a_ar[s] == 2'h2) ? 32'hFFFF_FFF0 - s : 32'h0000_0010;
         av = fetch(a_ar[s], a, full);
         bv = fetch(b_ar[s] == 2'h1 ? 2'h1 : 2'h0, 32'h0000_0020, full);
         prod = av * bv;
         dst = 16'h0040 + 16'(s * 8);
         gen[dst[7:0] - 8'h01] = 16'h1234;
         gen[dst[7:0] + 8'(nw)] = 16'h1234;
         run_op(full ? 2'h1 : 2'h0, 3'(s), a, 16'h0020, dst, 0);
         @(posedge core_clk);
         #1;
         chk(wr_cnt, nw, "multiply word count");
         chk({gen[dst[7:0] - 8'h01], gen[dst[7:0] + 8'(nw)]}, 32'h1234_1234, "spill");
         for (int w = 0; w < nw; w++) begin
            if (full) begin
               chk(gen[dst[7:0] + 8'(w)], prod[16*w +: 16], "full product word");
            end else begin
               chk(gen[dst[7:0] + 8'(w)], prod[16*w +: 16], "half product word");
            end
         end
      end
   endtask

   task automatic t_div;
      logic [31:0] av, bv, a;
      logic [15:0] dst;
      for (int s = 0; s < 6; s++) begin
         gen[8'h10] = (s == 4) ? 16'h0003 : 16'hFFFF - 16'(s * 16'h1111);
         par[8'h10] = 16'hE000 + 16'(s);
         gen[8'h20] = 16'h0007 + 16'(s);
         par[8'h20] = 16'h00F0 - 16'(s);
         a = (a_ar[s] == 2'h2) ? 32'h0001_FFFF - s : 32'h0000_0010;
         av = fetch(a_ar[s], a, 1'b0);
         bv = fetch(b_ar[s] == 2'h1 ? 2'h1 : 2'h0, 32'h0000_0020, 1'b0);
         dst = 16'h0080 + 16'(s * 4);
         run_op(2'h2, 3'(s), a, 16'h0020, dst, (s == 2) ? 6 : 0);
         @(posedge core_clk);
         #1;
         chk(wr_cnt, 2, "divide word count");
         chk(gen[dst[7:0]], av / bv, "quotient");
         chk(gen[dst[7:0] + 8'h01], av % bv, "remainder");
      end
   endtask

   task automatic t_div0;
      gen[8'h10] = 16'h9ABC;
      gen[8'h20] = 16'h0000;
      par[8'h20] = 16'h0000;
      run_op(2'h2, 3'h0, 32'h0000_0010, 16'h0020, 16'h00A0, 0);
      run_op(2'h2, 3'h3, 32'h0000_4321, 16'h0020, 16'h00A4, 0);
      @(posedge core_clk);
      #1;
      chk({gen[8'hA0], gen[8'hA1]}, 32'hFFFF_9ABC, "zero divisor gen");
      chk({gen[8'hA4], gen[8'hA5]}, 32'hFFFF_4321, "zero divisor imm");
   endtask

   task automatic t_illegal;
      logic [4:0] cs [0:2] = '{5'b11_000, 5'b00_110, 5'b10_111};
      for (int i = 0; i < 3; i++) begin
         wr_cnt = 0;
         issue(cs[i][4:3], cs[i][2:0], 32'h0000_0010, 16'h0020, 16'h00B0);
         chk({err, busy}, 2'b10, "illegal encoding not flagged");
         @(posedge core_clk);
         #1;
         chk(err, 0, "error pulse too long");
         repeat (6) @(posedge core_clk);
         #1;
         chk(wr_cnt, 0, "illegal encoding wrote");
      end
   endtask

   task automatic t_refuse;
      int n;
      wr_cnt = 0;
      gen[8'hD0] = 16'h5555;
      gen[8'h10] = 16'h0100;
      gen[8'h20] = 16'h0203;
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_kind  <= 2'h0;
      op_src   <= 3'h0;
      op_a     <= 32'h0000_0010;
      op_b     <= 16'h0020;
      op_dst   <= 16'h00C0;
      @(posedge core_clk);
      // Still requesting while busy: must be ignored
      op_dst   <= 16'h00D0;
      repeat (3) @(posedge core_clk);
      op_valid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      repeat (8) @(posedge core_clk);
      #1;
      chk(wr_cnt, 2, "request while busy taken");
      chk({gen[8'hC1], gen[8'hC0], gen[8'hD0]}, 48'h0002_0300_5555, "busy refusal");
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      give_verdict;
   end

   initial begin
      core_clk  = 1'b0;
      rstn      = 1'b0;
      clk_en    = 1'b1;
      op_valid  = 1'b0;
      op_kind   = 2'h0;
      op_src    = 3'h0;
      op_a      = 32'h0000_0000;
      op_b      = 16'h0000;
      op_dst    = 16'h0000;
      rd_data   = 16'h0000;
      err_count = 0;
      checks    = 0;
      wr_cnt    = 0;
      for (int i = 0; i < 256; i++) begin
         gen[i] = 16'hC000 | 16'(i);
         par[i] = 16'h3000 | 16'(i);
      end
      repeat (20) @(posedge core_clk);
      #1;
      chk({busy, done, err, rd_en, wr_en}, 0, "outputs during reset");
      @(posedge core_clk);
      rstn <= 1'b1;
      t_mul(1'b0);
      t_mul(1'b1);
      t_div;
      t_div0;
      t_illegal;
      t_refuse;
      give_verdict;
   end
endmodule
